/* tcm_pkg.sv */
// Purpose: Shared constants and types of the timer channel mode block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Channel control fields sit in the low byte of each control word
`default_nettype none

package tcm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_COUNT  = 8'h04;
    localparam logic [7:0] OFS_MODULO = 8'h08;
    localparam logic [7:0] OFS_CH0CTL = 8'h0c;
    localparam logic [7:0] OFS_CH0VAL = 8'h10;
    localparam logic [7:0] OFS_CH1CTL = 8'h14;
    localparam logic [7:0] OFS_CH1VAL = 8'h18;

    // Status register field positions
    localparam int BIT_HALT  = 5;
    localparam int BIT_CLEAR = 4;

    // Channel control field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_BMS  = 5;
    localparam int BIT_CCS  = 4;
    localparam int BIT_ELSH = 3;
    localparam int BIT_ELSL = 2;

    // Reset values
    localparam logic        RST_HALT   = 1'b1;
    localparam logic [15:0] RST_MODULO = 16'hffff;
    localparam logic [15:0] RST_COUNT  = 16'h0000;

    // Edge/level codes
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-channel control bits travel together
    typedef struct packed {
        logic       bms;
        logic       ccs;
        logic [1:0] els;
    } tcm_chan_ctrl_type;

    typedef enum logic [1:0] {
        TCM_PRESET,
        TCM_CAPTURE,
        TCM_COMPARE,
        TCM_BUF_COMPARE
    } tcm_mode_type;

endpackage

`default_nettype wire

/* tcm_edge_detect.sv */
// Purpose: Synchronise a channel pin and flag the selected capture edges
// Assumes: Pin is asynchronous to core_clk
// Notes:   Hit is combinational from flops, one cycle per edge
`default_nettype none

module tcm_edge_detect (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    output logic            hit
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic rise;
    logic fall;

    // Two-flop synchroniser, then one flop for edge history
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // Edge choice from the edge/level pair
    always_comb begin
        case (edge_sel)
            tcm_pkg::ELS_RISE: hit = rise;
            tcm_pkg::ELS_FALL: hit = fall;
            tcm_pkg::ELS_BOTH: hit = rise | fall;
            default:           hit = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

/* tcm_timer_channels.sv */
// Purpose: Two capture/compare channels of a 16-bit timer, AXI4-Lite regs
// Assumes: Single clock core_clk, async active-high rst
// Notes:   Channel 1 is swallowed by channel 0 in buffered mode
//
// Behaviour
// - Ch0 buffered mode disables ch1 register, pin
// - Reset clears every buffer-mode select bit
// - Buffer-mode bit one enables buffered compare
// - Nonzero edge pair: select picks capture/compare
// - Zero edge pair: select sets initial level
// - Reset clears every capture/compare select bit
// - Zero edge pair: pin under port control
// - Capture edges: 01 rise, 10 fall, 11 both
// - Unbuffered match: none, toggle, low, high
// - Buffered match: toggle, low, high
// - Edge bits steer capture logic, readable writable
`default_nettype none

module tcm_timer_channels #(
    parameter int CNT_W = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  channel_pin_in,
    output logic [1:0]       channel_pin_out,
    output logic [1:0]       channel_pin_oe
);

    tcm_pkg::tcm_chan_ctrl_type ctrl_q [2];
    tcm_pkg::tcm_mode_type      mode [2];
    logic [CNT_W-1:0] val_q [2];
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mod_q;
    logic [CNT_W-1:0] active_q;
    logic             last_wr_q;
    logic             halt_q;
    logic [1:0]       flag_q;
    logic [1:0]       hit;
    logic [1:0]       match;
    logic [1:0]       cap_ev;
    logic [1:0]       cmp_ev;
    logic             ovf;
    logic             clear_req;
    logic             aw_held_q;
    logic             w_held_q;
    logic [7:0]       aw_addr_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;
    logic             wr_fire;
    logic             wr_ok;
    logic [31:0]      rd_word;
    logic             rd_ok;

    localparam logic [CNT_W-1:0] RST_MODULO_W =
        tcm_pkg::RST_MODULO[CNT_W-1:0];

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Mode decode from control bits and the buffered takeover
    function automatic tcm_pkg::tcm_mode_type decode(
        input tcm_pkg::tcm_chan_ctrl_type c, input logic buf_on);
        tcm_pkg::tcm_mode_type m;
        if (c.els == tcm_pkg::ELS_NONE) begin
            m = tcm_pkg::TCM_PRESET;
        end else if (buf_on) begin
            m = tcm_pkg::TCM_BUF_COMPARE;
        end else if (c.ccs) begin
            m = tcm_pkg::TCM_COMPARE;
        end else begin
            m = tcm_pkg::TCM_CAPTURE;
        end
        return m;
    endfunction

    // Packs one channel control word for readback
    function automatic logic [31:0] ctl_word(
        input tcm_pkg::tcm_chan_ctrl_type c, input logic flag);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[tcm_pkg::BIT_FLAG] = flag;
        w[tcm_pkg::BIT_BMS]  = c.bms;
        w[tcm_pkg::BIT_CCS]  = c.ccs;
        w[tcm_pkg::BIT_ELSH] = c.els[1];
        w[tcm_pkg::BIT_ELSL] = c.els[0];
        return w;
    endfunction

    // Ch0 buffered mode drags ch1 back to port use
    always_comb begin
        mode[0] = decode(ctrl_q[0], ctrl_q[0].bms);
        if (ctrl_q[0].bms) begin
            mode[1] = tcm_pkg::TCM_PRESET;
        end else begin
            mode[1] = decode(ctrl_q[1], 1'b0);
        end
    end

    // Edge detection per channel
    for (genvar g = 0; g < 2; g++) begin : g_edge
        tcm_edge_detect u_edge (
            .core_clk (core_clk),
            .rst      (rst),
            .pin_in   (channel_pin_in[g]),
            .edge_sel (ctrl_q[g].els),
            .hit      (hit[g])
        );
    end

    // Buffered channel 0 compares against the latched active value
    assign match[0] = ~halt_q &
        (cnt_q == ((mode[0] == tcm_pkg::TCM_BUF_COMPARE) ? active_q
                                                         : val_q[0]));
    assign match[1] = ~halt_q & (cnt_q == val_q[1]);
    assign ovf      = ~halt_q & (cnt_q == mod_q);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cap_ev[i] = hit[i] & (mode[i] == tcm_pkg::TCM_CAPTURE);
            cmp_ev[i] = match[i] &
                        ((mode[i] == tcm_pkg::TCM_COMPARE) ||
                         (mode[i] == tcm_pkg::TCM_BUF_COMPARE));
        end
    end

    // Write channel: address and data may arrive in either order
    assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_ok   = (aw_addr_q <= tcm_pkg::OFS_CH1VAL) &&
                     (aw_addr_q[1:0] == 2'b00);
    assign clear_req = wr_fire && (aw_addr_q == tcm_pkg::OFS_STATUS) &&
                       w_strb_q[0] && w_data_q[tcm_pkg::BIT_CLEAR];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tcm_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? tcm_pkg::RESP_OKAY
                                      : tcm_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Status and modulo registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            halt_q <= tcm_pkg::RST_HALT;
            mod_q  <= RST_MODULO_W;
        end else if (wr_fire) begin
            if (aw_addr_q == tcm_pkg::OFS_STATUS && w_strb_q[0]) begin
                halt_q <= w_data_q[tcm_pkg::BIT_HALT];
            end
            if (aw_addr_q == tcm_pkg::OFS_MODULO) begin
                mod_q <= CNT_W'(merge(32'(mod_q), w_data_q,
                                      w_strb_q));
            end
        end
    end

    // Counter wraps at modulo; clear request wins over counting
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= tcm_pkg::RST_COUNT[CNT_W-1:0];
        end else if (clear_req) begin
            cnt_q <= tcm_pkg::RST_COUNT[CNT_W-1:0];
        end else if (ovf) begin
            cnt_q <= tcm_pkg::RST_COUNT[CNT_W-1:0];
        end else if (!halt_q) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Channel control bits; ch1 writes are dropped while ch0 buffers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_q[i] <= '0;
            end
        end else if (wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == tcm_pkg::OFS_CH0CTL) begin
                ctrl_q[0].bms <= w_data_q[tcm_pkg::BIT_BMS];
                ctrl_q[0].ccs <= w_data_q[tcm_pkg::BIT_CCS];
                ctrl_q[0].els <= w_data_q[tcm_pkg::BIT_ELSH:
                                          tcm_pkg::BIT_ELSL];
            end
            if (aw_addr_q == tcm_pkg::OFS_CH1CTL && !ctrl_q[0].bms) begin
                ctrl_q[1].ccs <= w_data_q[tcm_pkg::BIT_CCS];
                ctrl_q[1].els <= w_data_q[tcm_pkg::BIT_ELSH:
                                          tcm_pkg::BIT_ELSL];
            end
        end
    end

    // Channel flags: an event in the clearing cycle still sets the flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_ev[i] || cmp_ev[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (wr_fire && w_strb_q[0] &&
                             !w_data_q[tcm_pkg::BIT_FLAG] &&
                             aw_addr_q == (i == 0 ? tcm_pkg::OFS_CH0CTL
                                                  : tcm_pkg::OFS_CH1CTL)) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    end

    // Value registers: a capture overrides a software write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            val_q[0]  <= '0;
            val_q[1]  <= '0;
            last_wr_q <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_ev[i]) begin
                    val_q[i] <= cnt_q;
                end else if (wr_fire &&
                             aw_addr_q == (i == 0 ? tcm_pkg::OFS_CH0VAL
                                                  : tcm_pkg::OFS_CH1VAL)) begin
                    val_q[i]  <= CNT_W'(merge(32'(val_q[i]), w_data_q,
                                              w_strb_q));
                    last_wr_q <= (i == 1);
                end
            end
        end
    end

    // Buffered value moves in only at overflow, so no glitch mid-period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_q <= '0;
        end else if (ovf && ctrl_q[0].bms) begin
            active_q <= val_q[last_wr_q];
        end
    end

    // Pin drive: preset level, compare action, or released to the port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            channel_pin_out <= 2'b11;
            channel_pin_oe  <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                case (mode[i])
                    tcm_pkg::TCM_PRESET: begin
                        channel_pin_oe[i]  <= 1'b0;
                        channel_pin_out[i] <= ~ctrl_q[i].ccs;
                    end
                    tcm_pkg::TCM_CAPTURE: begin
                        channel_pin_oe[i] <= 1'b0;
                    end
                    tcm_pkg::TCM_COMPARE,
                    tcm_pkg::TCM_BUF_COMPARE: begin
                        channel_pin_oe[i] <= ~(ctrl_q[i].els ==
                                               tcm_pkg::ELS_NONE);
                        if (cmp_ev[i]) begin
                            case (ctrl_q[i].els)
                                tcm_pkg::ELS_RISE:
                                    channel_pin_out[i] <=
                                        ~channel_pin_out[i];
                                tcm_pkg::ELS_FALL:
                                    channel_pin_out[i] <= 1'b0;
                                tcm_pkg::ELS_BOTH:
                                    channel_pin_out[i] <= 1'b1;
                                default:
                                    channel_pin_out[i] <=
                                        channel_pin_out[i];
                            endcase
                        end
                    end
                    default: begin
                        channel_pin_oe[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Read decode; ch1 control reads zero while ch0 buffers
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            tcm_pkg::OFS_STATUS: rd_word[tcm_pkg::BIT_HALT] = halt_q;
            tcm_pkg::OFS_COUNT:  rd_word[CNT_W-1:0] = cnt_q;
            tcm_pkg::OFS_MODULO: rd_word[CNT_W-1:0] = mod_q;
            tcm_pkg::OFS_CH0CTL: rd_word = ctl_word(ctrl_q[0], flag_q[0]);
            tcm_pkg::OFS_CH0VAL: rd_word[CNT_W-1:0] = val_q[0];
            tcm_pkg::OFS_CH1CTL: begin
                if (!ctrl_q[0].bms) begin
                    rd_word = ctl_word(ctrl_q[1], flag_q[1]);
                end
            end
            tcm_pkg::OFS_CH1VAL: rd_word[CNT_W-1:0] = val_q[1];
            default:             rd_ok = 1'b0;
        endcase
    end

    // Read channel: one read in flight, answer the cycle after arready
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tcm_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? tcm_pkg::RESP_OKAY
                                      : tcm_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* tcm_port_chk.sv */
// Purpose: Port checker for the timer channel block
// Assumes: Bench offers write address and data at the same edge
// Notes:   Shadows the ch0 control bits as seen on the bus
`default_nettype none

module tcm_port_chk #(
    parameter int CNT_W = 16
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  channel_pin_in,
    input wire logic [1:0]  channel_pin_out,
    input wire logic [1:0]  channel_pin_oe
);
    logic [3:0] ctl_q;
    logic [2:0] age_q;
    logic       wr_both;
    logic       ch0_wr;
    logic       calm;

    // Shadow only ch0 control writes that strobe byte lane 0
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    assign ch0_wr = wr_both && s_axi_wstrb[0]
        && s_axi_awaddr == tcm_pkg::OFS_CH0CTL;
    assign calm = age_q >= 3'h3;

    // Shadow of bms, ccs, els
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 4'h0;
        end else if (ch0_wr) begin
            ctl_q <= s_axi_wdata[5:2];
        end
    end

    // Settle count gives the pin registers time to follow a write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            age_q <= 3'h0;
        end else if (ch0_wr) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    reset_pins_a: assert property (
        $fell(rst) |-> channel_pin_oe == 2'h0 && channel_pin_out == 2'h3)
        else $error("pins not at preset after reset");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid after read address");
    write_answer_a: assert property (
        wr_both |=> ##1 s_axi_bvalid)
        else $error("no bvalid after write");
    read_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    preset_pin_a: assert property (
        calm && ctl_q[1:0] == 2'h0
        |-> !channel_pin_oe[0] && channel_pin_out[0] == !ctl_q[2])
        else $error("preset level or port control wrong");
    capture_pin_a: assert property (
        calm && !ctl_q[3] && !ctl_q[2] |-> !channel_pin_oe[0])
        else $error("capture channel drives its pin");
    buf_pin1_a: assert property (
        calm && ctl_q[3] |-> !channel_pin_oe[1])
        else $error("ch1 pin driven in buffered mode");
    drive_pin_a: assert property (
        calm && ctl_q[1:0] != 2'h0 && (ctl_q[2] || ctl_q[3])
        |-> channel_pin_oe[0])
        else $error("compare channel not driving");
    clear_only_a: assert property (
        age_q >= 3'h4 && ctl_q[1:0] == 2'h2 && (ctl_q[2] || ctl_q[3])
        |-> !$rose(channel_pin_out[0]))
        else $error("pin rose in clear-on-match mode");
    set_only_a: assert property (
        age_q >= 3'h4 && ctl_q[1:0] == 2'h3 && (ctl_q[2] || ctl_q[3])
        |-> !$fell(channel_pin_out[0]))
        else $error("pin fell in set-on-match mode");

    preset_c: cover property (calm && ctl_q[1:0] == 2'h0 && ctl_q[2]);
    capture_c: cover property (calm && ctl_q == 4'h3);
    buffered_c: cover property (calm && ctl_q[3] && ctl_q[1:0] != 2'h0);
endmodule

bind tcm_timer_channels tcm_port_chk #(.CNT_W(CNT_W)) u_chk (.*);

`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the timer channel block
// Assumes: 125 MHz core_clk, register access over AXI4-Lite
// Notes:   Counter is halted and cleared before every mode change
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  channel_pin_in, channel_pin_out, channel_pin_oe;
    int          bad_count, tests_run, cycles;
    // Per compare case: preset, mode, level
    localparam logic [23:0] PRE  = 24'h10_00_10;
    localparam logic [23:0] MODE = 24'h2c_18_1c;
    localparam logic [2:0]  HIGH = 3'b101;

    tcm_timer_channels #(.CNT_W(16)) uut (.*);

    // Free-running clock, 8 ns period
    always #4 core_clk = ~core_clk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        chk_reg({30'h0, got}, {30'h0, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // AW and W offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Late rready exercises the held answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge core_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk_pin(r, tcm_pkg::RESP_OKAY);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk_reg(d, e);
        chk_pin(r, tcm_pkg::RESP_OKAY);
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [31:0] changes;
        logic        prev;
        core_clk = 1'b0;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_wstrb = 4'hf;
        channel_pin_in = 2'h0;
        wait_cyc(5);
        rst <= 1'b0;
        chk_pin(channel_pin_oe, 2'h0);
        chk_pin(channel_pin_out, 2'h3);
        rchk(tcm_pkg::OFS_STATUS, 32'h20);
        rchk(tcm_pkg::OFS_CH0CTL, 32'h0);
        $display("test reset done");
        wok(tcm_pkg::OFS_STATUS, 32'h30);
        wok(tcm_pkg::OFS_CH0CTL, 32'h30);
        wait_cyc(4);
        chk_pin({channel_pin_oe[0], channel_pin_out[0]}, 2'h0);
        rchk(tcm_pkg::OFS_CH0CTL, 32'h30);
        $display("test preset done");
        for (int code = 1; code < 4; code++) begin
            wok(tcm_pkg::OFS_CH0CTL, {28'h0, code[1:0], 2'h0});
            rchk(tcm_pkg::OFS_CH0CTL, {28'h0, code[1:0], 2'h0});
            for (int e = 0; e < 2; e++) begin
                wok(tcm_pkg::OFS_CH0VAL, 32'habcd);
                channel_pin_in[0] <= (e == 0);
                wait_cyc(8);
                rchk(tcm_pkg::OFS_CH0VAL, code[e] ? 32'h0 : 32'habcd);
            end
        end
        $display("test capture done");
        wok(tcm_pkg::OFS_MODULO, 32'h0f);
        wok(tcm_pkg::OFS_CH0VAL, 32'h05);
        for (int i = 0; i < 3; i++) begin
            wok(tcm_pkg::OFS_STATUS, 32'h30);
            wok(tcm_pkg::OFS_CH0CTL, {24'h0, PRE[8*i +: 8]});
            wok(tcm_pkg::OFS_CH0CTL, {24'h0, MODE[8*i +: 8]});
            wok(tcm_pkg::OFS_STATUS, 32'h00);
            wait_cyc(40);
            chk_pin({channel_pin_oe[0], channel_pin_out[0]}, {1'b1, HIGH[i]});
        end
        chk_pin({1'b0, channel_pin_oe[1]}, 2'h0);
        wok(tcm_pkg::OFS_STATUS, 32'h30);
        wok(tcm_pkg::OFS_CH0CTL, 32'h14);
        wok(tcm_pkg::OFS_STATUS, 32'h00);
        wait_cyc(20);
        changes = 32'h0;
        repeat (64) begin
            prev = channel_pin_out[0];
            @(posedge core_clk);
            if (channel_pin_out[0] !== prev) changes++;
        end
        chk_reg(changes, 32'h4);
        $display("test compare done");
        wok(tcm_pkg::OFS_STATUS, 32'h30);
        wok(tcm_pkg::OFS_CH0CTL, 32'h24);
        wok(tcm_pkg::OFS_CH1CTL, 32'h1c);
        rchk(tcm_pkg::OFS_CH1CTL, 32'h0);
        wait_cyc(4);
        chk_pin({1'b0, channel_pin_oe[1]}, 2'h0);
        wok(tcm_pkg::OFS_CH0CTL, 32'h00);
        wok(tcm_pkg::OFS_CH1CTL, 32'h1c);
        rchk(tcm_pkg::OFS_CH1CTL, 32'h1c);
        wait_cyc(4);
        chk_pin({1'b0, channel_pin_oe[1]}, 2'h1);
        $display("test channel one done");
        wr(8'h1c, 32'h1, r);
        chk_pin(r, tcm_pkg::RESP_SLVERR);
        rd(8'h06, d, r);
        chk_reg(d, 32'h0);
        chk_pin(r, tcm_pkg::RESP_SLVERR);
        $display("test unmapped done");
        complete_run();
    end
endmodule

`default_nettype wire
